/* File: core/pdrx_pkg.sv */
// Constants for the header and receive configuration register bank.
// Assumes an 8-bit register port decoded behind the serial management link.
package pdrx_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_INPUT_CAP = 8'h28;
  localparam logic [7:0] ADDR_OUTPUT_CAP = 8'h29;
  localparam logic [7:0] ADDR_MSG_HEADER = 8'h2e;
  localparam logic [7:0] ADDR_RX_DETECT = 8'h2f;
  localparam logic [7:0] ADDR_RX_BYTE_COUNT = 8'h30;

  // Fixed capability values: nothing external is present
  localparam logic [7:0] INPUT_CAP_VALUE = 8'h00;
  localparam logic [7:0] OUTPUT_CAP_VALUE = 8'h00;

  // Message header field positions
  localparam int HDR_POWER_ROLE_BIT = 0;
  localparam int HDR_REV_LSB = 1;
  localparam int HDR_REV_MSB = 2;
  localparam int HDR_DATA_ROLE_BIT = 3;
  localparam int HDR_CABLE_PLUG_BIT = 4;
  localparam int HDR_USED_BITS = 5;

  // Header reset value and its revision field
  localparam logic [7:0] MSG_HEADER_RESET = 8'h02;
  localparam logic [1:0] REV_1_0 = 2'h0;
  localparam logic [1:0] REV_2_0 = 2'h1;
  localparam logic [1:0] REV_3_0 = 2'h2;

  // Receive detect enable positions; bit 7 is reserved
  localparam int DET_USED_BITS = 7;
  localparam logic [7:0] RX_DETECT_RESET = 8'h00;

  // Frame type codes seen on the receive side
  localparam logic [2:0] FT_SOP = 3'h0;
  localparam logic [2:0] FT_PRIME = 3'h1;
  localparam logic [2:0] FT_DOUBLE_PRIME = 3'h2;
  localparam logic [2:0] FT_DBG_PRIME = 3'h3;
  localparam logic [2:0] FT_DBG_DOUBLE_PRIME = 3'h4;
  localparam logic [2:0] FT_HARD_RESET = 3'h5;
  localparam logic [2:0] FT_CABLE_RESET = 3'h6;

  // Byte count: frame type byte plus two header bytes
  localparam logic [7:0] RX_COUNT_OVERHEAD = 8'h03;
  localparam logic [7:0] RX_COUNT_RESET = 8'h00;

  // Answer for unmapped addresses
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

endpackage

/* File: core/pdrx_regs.sv */
// Header defaults, receive detect enables and receive byte count registers.
// Assumes a decoded 8-bit register port from the serial management link
// and single-cycle event pulses from the receive and transmit engines.
//
// Summary of operation
// - input capability register reads zero, read-only
// - output capability register reads zero, read-only
// - header holds cable plug, data and power roles
// - two-bit revision field, default revision two
// - hard reset detection clears receive detect register
// - disconnect leaves receive detect; software clears it
// - frame type received only when enabled
// - byte count cleared on hard reset, disconnect
// - byte count cleared when receive flag cleared
// - byte count is data bytes plus three
`timescale 1ns/1ps

module pdrx_regs #(
  parameter int OBJ_W = 5 // Width of the data object byte count
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic rx_start,
  input wire logic [2:0] rx_frame_type,
  output logic rx_accept,
  input wire logic rx_done,
  input wire logic [OBJ_W-1:0] rx_obj_bytes,
  input wire logic hard_reset_rx,
  input wire logic hard_reset_tx,
  input wire logic disconnect_det,
  input wire logic rx_message_flag_clr,
  output logic cable_plug,
  output logic data_role,
  output logic [1:0] protocol_revision,
  output logic power_role,
  output logic [6:0] rx_enables
);

  ////////////////////////////////////////////////////////////////////////
  // Storage

  // Writable header fields, reserved bits not stored
  logic [4:0] header_q;
  // Receive detect enables, bit 7 reserved and not stored
  logic [6:0] detect_q;
  // Receive byte count
  logic [7:0] count_q;
  // Read data holder
  logic [7:0] rdata_q;
  // Frame in progress was accepted
  logic frame_ok_q;

  // Write strobes per register
  logic wr_header;
  logic wr_detect;

  // Writes to read-only or unmapped offsets decode to nothing at all
  assign wr_header = reg_wr && (reg_addr == pdrx_pkg::ADDR_MSG_HEADER);
  assign wr_detect = reg_wr && (reg_addr == pdrx_pkg::ADDR_RX_DETECT);

  ////////////////////////////////////////////////////////////////////////
  // Message header defaults

  // Bits 7:5 are dropped so stray software values cannot leak out
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      header_q <= pdrx_pkg::MSG_HEADER_RESET[4:0];
    end else if (wr_header) begin
      header_q <= reg_wdata[4:0];
    end
  end

  // Header fields go straight to the transmit framer
  assign power_role = header_q[pdrx_pkg::HDR_POWER_ROLE_BIT];
  assign protocol_revision =
    header_q[pdrx_pkg::HDR_REV_MSB:pdrx_pkg::HDR_REV_LSB];
  assign data_role = header_q[pdrx_pkg::HDR_DATA_ROLE_BIT];
  assign cable_plug = header_q[pdrx_pkg::HDR_CABLE_PLUG_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Receive detect enables

  // Hard reset clears even a write in the same cycle; a disconnect does
  // nothing here, so software must clear the enables itself
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      detect_q <= pdrx_pkg::RX_DETECT_RESET[6:0];
    end else if (hard_reset_rx) begin
      detect_q <= pdrx_pkg::RX_DETECT_RESET[6:0];
    end else if (wr_detect) begin
      detect_q <= reg_wdata[6:0];
    end
  end

  // Enables go straight to the receive engine
  assign rx_enables = detect_q;

  // Accept a start only for an enabled frame type
  always_comb begin
    rx_accept = 1'b0;
    if (rx_start) begin
      case (rx_frame_type)
        pdrx_pkg::FT_SOP: rx_accept = detect_q[0];
        pdrx_pkg::FT_PRIME: rx_accept = detect_q[1];
        pdrx_pkg::FT_DOUBLE_PRIME: rx_accept = detect_q[2];
        pdrx_pkg::FT_DBG_PRIME: rx_accept = detect_q[3];
        pdrx_pkg::FT_DBG_DOUBLE_PRIME: rx_accept = detect_q[4];
        pdrx_pkg::FT_HARD_RESET: rx_accept = detect_q[5];
        pdrx_pkg::FT_CABLE_RESET: rx_accept = detect_q[6];
        default: rx_accept = 1'b0; // Reserved code 7, never accepted
      endcase
    end
  end

  // Remember whether the current frame was accepted
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frame_ok_q <= 1'b0;
    end else if (rx_start) begin
      frame_ok_q <= rx_accept;
    end else if (rx_done || hard_reset_rx || disconnect_det) begin
      frame_ok_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive byte count

  // Loaded count: objects plus type byte and two header bytes
  logic [7:0] count_d;
  assign count_d = 8'(rx_obj_bytes) + pdrx_pkg::RX_COUNT_OVERHEAD;

  // Hard reset and disconnect beat a finishing frame; a finishing frame
  // beats a flag clear, so a message landing then is not lost
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_q <= pdrx_pkg::RX_COUNT_RESET;
    end else if (hard_reset_rx || hard_reset_tx || disconnect_det) begin
      count_q <= pdrx_pkg::RX_COUNT_RESET;
    end else if (rx_done && frame_ok_q) begin
      count_q <= count_d;
    end else if (rx_message_flag_clr) begin
      count_q <= pdrx_pkg::RX_COUNT_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  // Read data is held until the next read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= pdrx_pkg::UNMAPPED_VALUE;
    end else if (reg_rd) begin
      case (reg_addr)
        pdrx_pkg::ADDR_INPUT_CAP:
          rdata_q <= pdrx_pkg::INPUT_CAP_VALUE;
        pdrx_pkg::ADDR_OUTPUT_CAP:
          rdata_q <= pdrx_pkg::OUTPUT_CAP_VALUE;
        pdrx_pkg::ADDR_MSG_HEADER: rdata_q <= {3'h0, header_q};
        pdrx_pkg::ADDR_RX_DETECT: rdata_q <= {1'b0, detect_q};
        pdrx_pkg::ADDR_RX_BYTE_COUNT: rdata_q <= count_q;
        default: rdata_q <= pdrx_pkg::UNMAPPED_VALUE; // Unmapped reads zero
      endcase
    end
  end

  // Registered so the serial side sees a steady byte while it shifts
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  input_cap_zero_a: assert property (
    reg_rd && reg_addr == pdrx_pkg::ADDR_INPUT_CAP |=> reg_rdata == 8'h00)
    else $error("input capability read not zero");

  output_cap_zero_a: assert property (
    reg_rd && reg_addr == pdrx_pkg::ADDR_OUTPUT_CAP |=> reg_rdata == 8'h00)
    else $error("output capability read not zero");

  header_write_a: assert property (
    wr_header |=> {cable_plug, data_role, protocol_revision, power_role}
      == $past(reg_wdata[4:0]))
    else $error("header fields did not take the write");

  header_rsvd_a: assert property (
    reg_rd && reg_addr == pdrx_pkg::ADDR_MSG_HEADER |=> reg_rdata[7:5] == 3'h0)
    else $error("reserved header bits read non-zero");

  detect_hr_clear_a: assert property (
    hard_reset_rx |=> rx_enables == 7'h00)
    else $error("hard reset did not clear detect enables");

  detect_disc_keep_a: assert property (
    disconnect_det && !hard_reset_rx && !wr_detect |=> $stable(rx_enables))
    else $error("disconnect changed detect enables");

  accept_enable_a: assert property (
    rx_accept |-> rx_start && rx_frame_type != 3'h7 &&
      rx_enables[rx_frame_type])
    else $error("frame accepted while disabled");

  count_hr_clear_a: assert property (
    hard_reset_rx || hard_reset_tx || disconnect_det |=> count_q == 8'h00)
    else $error("byte count not cleared on reset or disconnect");

  count_flag_clear_a: assert property (
    rx_message_flag_clr && !(rx_done && frame_ok_q) |=> count_q == 8'h00)
    else $error("byte count not cleared on flag clear");

  count_load_a: assert property (
    rx_start && rx_accept ##1 !rx_start && !hard_reset_rx [*1] ##0
      (rx_done && !hard_reset_tx && !disconnect_det)
      |=> count_q == 8'($past(rx_obj_bytes)) + 8'h03)
    else $error("byte count not objects plus three");

  count_load_b_a: assert property (
    rx_done && frame_ok_q && !hard_reset_rx && !hard_reset_tx &&
      !disconnect_det |=> count_q == 8'($past(rx_obj_bytes)) + 8'h03)
    else $error("byte count load wrong");

  // A refused frame must leave the count alone
  count_refuse_a: assert property (
    rx_done && !frame_ok_q && !hard_reset_rx && !hard_reset_tx &&
      !disconnect_det && !rx_message_flag_clr |=> $stable(count_q))
    else $error("refused frame changed byte count");

  // Count is read-only: a write to it, or no event at all, keeps it
  count_hold_a: assert property (
    !rx_done && !hard_reset_rx && !hard_reset_tx && !disconnect_det &&
      !rx_message_flag_clr |=> $stable(count_q))
    else $error("byte count changed without an event");

  // Enables move only by software write or hard reset
  detect_hold_a: assert property (
    !hard_reset_rx && !wr_detect |=> $stable(rx_enables))
    else $error("detect enables changed without a cause");

  detect_write_a: assert property (
    wr_detect && !hard_reset_rx |=> rx_enables == $past(reg_wdata[6:0]))
    else $error("detect enables did not take the write");

  // Header survives hard reset and detach; software restores it itself
  header_hold_a: assert property (
    !wr_header |=> $stable(header_q))
    else $error("header changed without a write");

  // Read data mirrors each register as it stood at the strobe
  header_read_a: assert property (
    reg_rd && reg_addr == pdrx_pkg::ADDR_MSG_HEADER |=>
      reg_rdata == {3'h0, $past(header_q)})
    else $error("header read does not match contents");

  detect_read_a: assert property (
    reg_rd && reg_addr == pdrx_pkg::ADDR_RX_DETECT |=>
      reg_rdata == {1'b0, $past(rx_enables)})
    else $error("detect read does not match contents");

  detect_rsvd_a: assert property (
    reg_rd && reg_addr == pdrx_pkg::ADDR_RX_DETECT |=> reg_rdata[7] == 1'b0)
    else $error("reserved detect bit read non-zero");

  count_read_a: assert property (
    reg_rd && reg_addr == pdrx_pkg::ADDR_RX_BYTE_COUNT |=>
      reg_rdata == $past(count_q))
    else $error("byte count read does not match contents");

  unmapped_zero_a: assert property (
    reg_rd && reg_addr != pdrx_pkg::ADDR_INPUT_CAP &&
      reg_addr != pdrx_pkg::ADDR_OUTPUT_CAP &&
      reg_addr != pdrx_pkg::ADDR_MSG_HEADER &&
      reg_addr != pdrx_pkg::ADDR_RX_DETECT &&
      reg_addr != pdrx_pkg::ADDR_RX_BYTE_COUNT |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // Read data stands until the next read strobe
  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // Every enabled start is taken, and nothing is taken without a start
  accept_type_a: assert property (
    rx_start && rx_frame_type != 3'h7 && rx_enables[rx_frame_type]
      |-> rx_accept)
    else $error("enabled frame type not accepted");

  accept_idle_a: assert property (
    !rx_start |-> !rx_accept)
    else $error("accept raised without a frame start");

  ////////////////////////////////////////////////////////////////////////
  // Coverage of the main scenarios

  cov_frame_c: cover property (rx_start && rx_accept ##[1:40] rx_done);
  cov_reject_c: cover property (rx_start && !rx_accept);
  cov_hard_reset_c: cover property (count_q != 8'h00 ##1 hard_reset_rx);
  cov_flag_clear_c: cover property (count_q != 8'h00 ##1 rx_message_flag_clr);
  cov_count_read_c: cover property (
    reg_rd && reg_addr == pdrx_pkg::ADDR_RX_BYTE_COUNT && count_q != 8'h00);

endmodule // pdrx_regs

/* File: testbench/pdrx_pm.sv */
// Port manager model: reads and writes bytes over the decoded reg port.
// Assumes strobes sampled on the rising edge of clk, one per transfer.
`timescale 1ns/1ps

module pdrx_pm (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  ////////////////////////////////////////////////////////////////////
  // Idle port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One write; idle lines then show the inverse, never stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // One read; data taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  // Header write with reserved bits forced to zero
  task automatic hdr(input logic cp, input logic dr, input logic [1:0] rv,
                     input logic pr);
    wr(pdrx_pkg::ADDR_MSG_HEADER, {3'h0, cp, dr, rv, pr});
  endtask

  // Cleanup a manager owes the device after every detach
  task automatic detach_cleanup();
    wr(pdrx_pkg::ADDR_MSG_HEADER, pdrx_pkg::MSG_HEADER_RESET);
    wr(pdrx_pkg::ADDR_RX_DETECT, 8'h00);
  endtask
endmodule // pdrx_pm

/* File: testbench/pdrx_regs_tb_top.sv */
// Testbench for the header and receive configuration register bank.
// Assumes the port manager model drives the reg port; bench drives events.
`timescale 1ns/1ps

module pdrx_regs_tb_top;
  logic clk, reset_n, reg_wr, reg_rd, rx_start, rx_done, rx_accept;
  logic hard_reset_rx, hard_reset_tx, disconnect_det, rx_message_flag_clr;
  logic cable_plug, data_role, power_role;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [2:0] rx_frame_type;
  logic [4:0] rx_obj_bytes;
  logic [1:0] protocol_revision;
  logic [6:0] rx_enables;
  int mismatches, checks_done;
  logic [7:0] ro [4] = '{8'h28, 8'h29, 8'h30, 8'h7f};

  pdrx_regs dut_u (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .rx_start, .rx_frame_type, .rx_accept, .rx_done,
    .rx_obj_bytes, .hard_reset_rx, .hard_reset_tx, .disconnect_det,
    .rx_message_flag_clr, .cable_plug, .data_role, .protocol_revision,
    .power_role, .rx_enables);
  pdrx_pm pm_u (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);

  ////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task complete_run();
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  task rdc(input logic [7:0] a, input logic [7:0] e);
    pm_u.rd(a, v);
    chk(v, e);
  endtask

  // One-cycle event pulse
  task automatic pulse(ref logic s);
    @(posedge clk) #1;
    s = 1'b1;
    @(posedge clk) #1;
    s = 1'b0;
  endtask

  // Frame start, accept judged in that cycle, then done with a count
  task frame(input logic [2:0] t, input logic [4:0] n, input logic acc);
    @(posedge clk) #1;
    rx_start = 1'b1;
    rx_frame_type = t;
    #1 chk({7'h0, rx_accept}, {7'h0, acc});
    @(posedge clk) #1;
    rx_start = 1'b0;
    rx_done = 1'b1;
    rx_obj_bytes = n;
    @(posedge clk) #1;
    rx_done = 1'b0;
    rx_frame_type = ~t;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Reset values, and writes to read-only or unmapped places ignored
  task sc_caps();
    rdc(8'h2e, 8'h02);
    rdc(8'h2f, 8'h00);
    for (int i = 0; i < 4; i++) begin
      pm_u.wr(ro[i], 8'hff);
      rdc(ro[i], 8'h00);
    end
  endtask

  // Header fields: reserved bits dropped, every revision code held
  task sc_header();
    pm_u.wr(8'h2e, 8'hff);
    rdc(8'h2e, 8'h1f);
    chk({3'h0, cable_plug, data_role, protocol_revision, power_role},
        8'h1f);
    for (int r = 0; r < 3; r++) begin
      pm_u.hdr(1'b0, 1'b1, 2'(r), 1'b0);
      chk({6'h0, protocol_revision}, 8'(r));
    end
    pm_u.detach_cleanup();
    rdc(8'h2e, 8'h02);
  endtask

  // Each frame type accepted only with its own enable bit
  task sc_detect();
    pm_u.wr(8'h2f, 8'hff);
    rdc(8'h2f, 8'h7f);
    for (int t = 0; t < 7; t++) begin
      pm_u.wr(8'h2f, 8'(1 << t));
      chk({1'b0, rx_enables}, 8'(1 << t));
      frame(3'(t), 5'h00, 1'b1);
      pm_u.wr(8'h2f, 8'(7'h7f ^ (1 << t)));
      frame(3'(t), 5'h00, 1'b0);
    end
  endtask

  // Byte count loads and every clearing event
  task sc_count();
    pm_u.wr(8'h2f, 8'h01);
    frame(3'h0, 5'h04, 1'b1);
    rdc(8'h30, 8'h07);
    pulse(rx_message_flag_clr);
    rdc(8'h30, 8'h00);
    frame(3'h1, 5'h09, 1'b0);
    rdc(8'h30, 8'h00);
    frame(3'h0, 5'h1c, 1'b1);
    rdc(8'h30, 8'h1f);
    pulse(hard_reset_tx);
    rdc(8'h30, 8'h00);
    frame(3'h0, 5'h04, 1'b1);
    rdc(8'h30, 8'h07);
    pulse(disconnect_det);
    rdc(8'h30, 8'h00);
    rdc(8'h2f, 8'h01);
    frame(3'h0, 5'h04, 1'b1);
    rdc(8'h30, 8'h07);
    pulse(hard_reset_rx);
    rdc(8'h30, 8'h00);
    rdc(8'h2f, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {reset_n, rx_start, rx_done, hard_reset_rx, hard_reset_tx} = '0;
    {disconnect_det, rx_message_flag_clr, rx_frame_type} = '0;
    rx_obj_bytes = 5'h00;
    repeat (20) @(posedge clk);
    #1 reset_n = 1'b1;
    sc_caps();
    sc_header();
    sc_detect();
    sc_count();
    complete_run();
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
endmodule // pdrx_regs_tb_top
